// file: core/mpb_consts.svh
// Constants for the multiprocessor bus-sharing block.
// Assumes inclusion by bare name from the core files.
`ifndef MPB_CONSTS_SVH
`define MPB_CONSTS_SVH

// ----------------------------------------
// Timing and widths
// ----------------------------------------
`define MPB_CLK_PERIOD_NS 4
`define MPB_WAIT_RETEST_CLOCKS 5
`define MPB_ESC_BITS 6

// ----------------------------------------
// Queue status encodings
// ----------------------------------------
`define MPB_QS_NONE 2'h0
`define MPB_QS_FIRST 2'h1
`define MPB_QS_EMPTY 2'h2
`define MPB_QS_SUBSEQ 2'h3

`endif

// file: core/mpb_pkg.sv
// Types for the multiprocessor bus-sharing block.
// Assumes the constants header is compiled alongside.
package mpb_pkg;
  // Request/grant line owner states
  typedef enum logic [3:0] {
    MPB_OWN_LOCAL = 4'h1,
    MPB_OWN_HIGH = 4'h2,
    MPB_OWN_LOW = 4'h4,
    MPB_OWN_HOLD = 4'h8
  } mpb_own_e;
endpackage

// file: core/mpb_rqgt_port.sv
// One request/grant line: decodes pulses from the borrower and drives grant.
// Assumes the line is sampled synchronously to i_mclk, active low.
`timescale 1ns/100ps
`default_nettype none
module mpb_rqgt_port (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_line_n,
  input wire logic i_grant,
  output logic o_line_n,
  output logic o_line_oe_n,
  output logic o_pulse
);
  // ----------------------------------------
  // Pulse detect and grant drive
  // ----------------------------------------
  logic prev_ff;

  // Falling edge of the sampled line is one pulse
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      prev_ff <= 1'b1;
      o_pulse <= 1'b0;
    end else begin
      prev_ff <= i_line_n;
      o_pulse <= prev_ff & ~i_line_n & o_line_oe_n;
    end
  end

  // One-clock low grant pulse driven on the line
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_line_n <= 1'b1;
      o_line_oe_n <= 1'b1;
    end else begin
      o_line_n <= ~i_grant;
      o_line_oe_n <= ~i_grant;
    end
  end
endmodule
`default_nettype wire

// file: core/mpb_bus_share.sv
// Multiprocessor bus-sharing logic: exclusive-bus output, wait/sync,
// coprocessor handoff visibility and request/grant arbitration.
// Assumes the execution and bus units drive their status pulses on i_mclk.
//
// Notes on behaviour
// - Exclusive output rises on prefix, maximum mode.
// - Exclusive held through next instruction only.
// - Gap between two back-to-back prefixed instructions.
// - Prefixed repeated string stays exclusive throughout.
// - Prefix never touches interrupt recognition.
// - Requests during prefixed instruction wait recorded.
// - Minimum mode: no exclusive output.
// - Minimum mode: hold acknowledge waits on prefix.
// - Wait resamples sync input every five clocks.
// - Active sync input continues immediately.
// - Handoff instruction exposes six selector bits.
// - Maximum mode uses two request/grant lines.
// - Request pulse, grant pulse, bus released.
// - Bus unit disconnected while granted.
// - Execution continues until bus need or empty.
// - High line wins; low waits bus return.
// - No preemption of a low-line grant.
// - Minimum mode: finish cycle, acknowledge, hold off.
// - Exclusive during both interrupt acknowledge cycles.
`timescale 1ns/100ps
`default_nettype none
`include "mpb_consts.svh"
module mpb_bus_share #(
  parameter int RETEST_CLOCKS = `MPB_WAIT_RETEST_CLOCKS,
  parameter int ESC_BITS = `MPB_ESC_BITS
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_max_mode,
  input wire logic i_prefix_exec,
  input wire logic i_instr_end,
  input wire logic i_rep_active,
  input wire logic i_inta_active,
  input wire logic i_wait_exec,
  input wire logic i_sync_n,
  input wire logic i_esc_fetch,
  input wire logic [ESC_BITS-1:0] i_esc_sel,
  input wire logic [1:0] i_queue_state,
  input wire logic i_cycle_busy,
  input wire logic i_eu_needs_bus,
  input wire logic i_queue_empty,
  input wire logic i_takeover_req,
  input wire logic i_req_grant_high_prio_n,
  input wire logic i_req_grant_low_prio_n,
  output logic o_req_grant_high_prio_n,
  output logic o_req_grant_high_prio_oe_n,
  output logic o_req_grant_low_prio_n,
  output logic o_req_grant_low_prio_oe_n,
  output logic o_exclusive_n,
  output logic o_takeover_acknowledge,
  output logic o_bus_interface_unit_off,
  output logic o_execution_unit_stall,
  output logic o_wait_done,
  output logic o_coprocessor_handoff_instr,
  output logic [ESC_BITS-1:0] o_handoff_sel,
  output logic o_queue_state_bit0,
  output logic o_queue_state_bit1
);
  // ----------------------------------------
  // Local signals
  // ----------------------------------------
  mpb_pkg::mpb_own_e own_ff;
  mpb_pkg::mpb_own_e nxt_own;
  logic armed_ff;
  logic locked_ff;
  logic hi_pend_ff;
  logic lo_pend_ff;
  logic hi_pulse;
  logic lo_pulse;
  logic grant_hi;
  logic grant_lo;
  logic waiting_ff;
  logic [2:0] retest_ff;
  logic lock_busy;

  // Armed cycle counts as locked so no grant slips in before the lock lands
  assign lock_busy = armed_ff | locked_ff | i_inta_active;

  // ----------------------------------------
  // Exclusive-bus tracking
  // ----------------------------------------
  // Prefix arms; the next instruction runs locked until its end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      armed_ff <= 1'b0;
      locked_ff <= 1'b0;
    end else begin
      if (i_prefix_exec) begin
        armed_ff <= 1'b1;
      end else if (armed_ff) begin
        armed_ff <= 1'b0;
        locked_ff <= 1'b1;
      end else if (locked_ff && i_instr_end && !i_rep_active) begin
        locked_ff <= 1'b0;
      end
    end
  end

  // Exclusive pin only in maximum mode; drops for a clock between locks
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_exclusive_n <= 1'b1;
    end else begin
      // Interrupt acknowledge cycles also lock, prefix ignores interrupts
      o_exclusive_n <= ~(i_max_mode & (armed_ff | (locked_ff & ~i_instr_end) |
                                       (locked_ff & i_rep_active) | i_inta_active));
    end
  end

  // ----------------------------------------
  // Wait / sync input
  // ----------------------------------------
  // Idle while sync inactive, retesting every few clocks
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      waiting_ff <= 1'b0;
      retest_ff <= 3'h0;
      o_wait_done <= 1'b0;
    end else begin
      o_wait_done <= 1'b0;
      if (i_wait_exec && !waiting_ff) begin
        if (!i_sync_n) begin
          o_wait_done <= 1'b1;
        end else begin
          waiting_ff <= 1'b1;
          retest_ff <= 3'(RETEST_CLOCKS - 1);
        end
      end else if (waiting_ff) begin
        if (retest_ff != 3'h0) begin
          retest_ff <= retest_ff - 3'h1;
        end else if (!i_sync_n) begin
          waiting_ff <= 1'b0;
          o_wait_done <= 1'b1;
        end else begin
          retest_ff <= 3'(RETEST_CLOCKS - 1);
        end
      end
    end
  end

  // ----------------------------------------
  // Coprocessor handoff visibility
  // ----------------------------------------
  // Registered copy of handoff fetch, selector and queue status
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_coprocessor_handoff_instr <= 1'b0;
      o_handoff_sel <= '0;
      o_queue_state_bit0 <= 1'b0;
      o_queue_state_bit1 <= 1'b0;
    end else begin
      o_coprocessor_handoff_instr <= i_esc_fetch;
      if (i_esc_fetch) begin
        o_handoff_sel <= i_esc_sel;
      end
      o_queue_state_bit0 <= i_queue_state[0];
      o_queue_state_bit1 <= i_queue_state[1];
    end
  end

  // ----------------------------------------
  // Request/grant lines
  // ----------------------------------------
  mpb_rqgt_port u_high (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_line_n(i_req_grant_high_prio_n),
    .i_grant(grant_hi),
    .o_line_n(o_req_grant_high_prio_n),
    .o_line_oe_n(o_req_grant_high_prio_oe_n),
    .o_pulse(hi_pulse)
  );

  mpb_rqgt_port u_low (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_line_n(i_req_grant_low_prio_n),
    .i_grant(grant_lo),
    .o_line_n(o_req_grant_low_prio_n),
    .o_line_oe_n(o_req_grant_low_prio_oe_n),
    .o_pulse(lo_pulse)
  );

  // Grant only when local, idle, not locked; high wins
  assign grant_hi = (own_ff == mpb_pkg::MPB_OWN_LOCAL) & i_max_mode & hi_pend_ff &
                    ~lock_busy & ~i_cycle_busy;
  assign grant_lo = (own_ff == mpb_pkg::MPB_OWN_LOCAL) & i_max_mode & lo_pend_ff &
                    ~hi_pend_ff & ~lock_busy & ~i_cycle_busy;

  // Requests recorded; set wins over clear on the same line
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      hi_pend_ff <= 1'b0;
      lo_pend_ff <= 1'b0;
    end else begin
      if (own_ff == mpb_pkg::MPB_OWN_LOCAL && hi_pulse) begin
        hi_pend_ff <= 1'b1;
      end else if (own_ff == mpb_pkg::MPB_OWN_LOW && hi_pulse) begin
        hi_pend_ff <= 1'b1;
      end else if (grant_hi) begin
        hi_pend_ff <= 1'b0;
      end
      if (own_ff != mpb_pkg::MPB_OWN_LOW && lo_pulse) begin
        lo_pend_ff <= 1'b1;
      end else if (grant_lo) begin
        lo_pend_ff <= 1'b0;
      end
    end
  end

  // Owner state selection
  always_comb begin
    nxt_own = own_ff;
    unique case (own_ff)
      mpb_pkg::MPB_OWN_LOCAL: begin
        if (grant_hi) begin
          nxt_own = mpb_pkg::MPB_OWN_HIGH;
        end else if (grant_lo) begin
          nxt_own = mpb_pkg::MPB_OWN_LOW;
        end else if (!i_max_mode && i_takeover_req && !lock_busy && !i_cycle_busy) begin
          nxt_own = mpb_pkg::MPB_OWN_HOLD;
        end
      end
      mpb_pkg::MPB_OWN_HIGH: begin
        if (hi_pulse) begin
          nxt_own = mpb_pkg::MPB_OWN_LOCAL;
        end
      end
      mpb_pkg::MPB_OWN_LOW: begin
        if (lo_pulse) begin
          nxt_own = mpb_pkg::MPB_OWN_LOCAL;
        end
      end
      mpb_pkg::MPB_OWN_HOLD: begin
        if (!i_takeover_req) begin
          nxt_own = mpb_pkg::MPB_OWN_LOCAL;
        end
      end
      default: begin
        nxt_own = mpb_pkg::MPB_OWN_LOCAL;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      own_ff <= mpb_pkg::MPB_OWN_LOCAL;
    end else begin
      own_ff <= nxt_own;
    end
  end

  // ----------------------------------------
  // Bus release status
  // ----------------------------------------
  // Disconnect while away; stall execution on bus need or empty queue
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_takeover_acknowledge <= 1'b0;
      o_bus_interface_unit_off <= 1'b0;
      o_execution_unit_stall <= 1'b0;
    end else begin
      o_takeover_acknowledge <= (nxt_own == mpb_pkg::MPB_OWN_HOLD);
      o_bus_interface_unit_off <= (nxt_own != mpb_pkg::MPB_OWN_LOCAL);
      o_execution_unit_stall <= (nxt_own != mpb_pkg::MPB_OWN_LOCAL) &
                                (i_eu_needs_bus | i_queue_empty);
    end
  end
endmodule
`default_nettype wire

// file: tb/mpb_bus_share_monitor.sv
// Checker for the bus-sharing block, bound to its top module.
// Assumes one clock i_mclk and async reset i_rst, active high.
`timescale 1ns/100ps
`default_nettype none
module mpb_bus_share_monitor #(
  parameter int ESC_BITS = 6
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_max_mode,
  input wire logic i_prefix_exec,
  input wire logic i_instr_end,
  input wire logic i_rep_active,
  input wire logic i_inta_active,
  input wire logic i_wait_exec,
  input wire logic i_sync_n,
  input wire logic i_esc_fetch,
  input wire logic [ESC_BITS-1:0] i_esc_sel,
  input wire logic o_req_grant_high_prio_n,
  input wire logic o_req_grant_high_prio_oe_n,
  input wire logic o_req_grant_low_prio_oe_n,
  input wire logic o_exclusive_n,
  input wire logic o_bus_interface_unit_off,
  input wire logic o_wait_done,
  input wire logic o_coprocessor_handoff_instr,
  input wire logic [ESC_BITS-1:0] o_handoff_sel
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  lock_rise_a: assert property (i_max_mode && i_prefix_exec |-> ##2 !o_exclusive_n)
    else $error("exclusive not raised");
  lock_drop_a: assert property (
    i_instr_end && !i_rep_active && !i_inta_active && !i_prefix_exec |=> o_exclusive_n)
    else $error("exclusive held past instruction");
  lock_rep_a: assert property (!o_exclusive_n && i_rep_active |=> !o_exclusive_n)
    else $error("exclusive dropped in string");
  lock_min_a: assert property (!i_max_mode && $past(!i_max_mode) |-> o_exclusive_n)
    else $error("exclusive in minimum mode");
  lock_inta_a: assert property (i_max_mode && i_inta_active |=> !o_exclusive_n)
    else $error("exclusive missing in acknowledge");
  grant_pulse_a: assert property (
    !o_req_grant_high_prio_oe_n |-> !o_req_grant_high_prio_n ##1 o_req_grant_high_prio_oe_n)
    else $error("grant pulse not one clock low");
  grant_off_a: assert property (
    !o_req_grant_high_prio_oe_n || !o_req_grant_low_prio_oe_n |-> o_bus_interface_unit_off)
    else $error("bus unit not off at grant");
  esc_show_a: assert property (
    i_esc_fetch |=> o_coprocessor_handoff_instr && o_handoff_sel == $past(i_esc_sel))
    else $error("handoff not shown");
  wait_now_a: assert property (i_wait_exec && !i_sync_n |=> o_wait_done)
    else $error("wait not done at once");
  wait_idle_a: assert property (i_wait_exec && i_sync_n |=> !o_wait_done [*4])
    else $error("wait ended before retest");
endmodule
bind mpb_bus_share mpb_bus_share_monitor #(.ESC_BITS(ESC_BITS)) mon_u (.*);
`default_nettype wire

// file: tb/mpb_borrower.sv
// Borrowing master on one request/grant line.
// Assumes the bench forms the wired line level from all drivers.
`timescale 1ns/100ps
`default_nettype none
module mpb_borrower #(
  parameter int HOLD = 3
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_line_n,
  output logic o_line_n,
  output logic o_owner
);
  logic [1:0] st_ff;
  logic [7:0] cnt_ff;
  assign o_owner = (st_ff == 2'h2);
  // Request, await grant, hold, release; pulses one clock low
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= 2'h0;
      cnt_ff <= 8'h00;
      o_line_n <= 1'b1;
    end else begin
      o_line_n <= 1'b1;
      cnt_ff <= cnt_ff + 8'h01;
      case (st_ff)
        2'h0: if (i_go) begin
          o_line_n <= 1'b0;
          st_ff <= 2'h1;
        end
        2'h1: if (o_line_n && !i_line_n) begin
          st_ff <= 2'h2;
          cnt_ff <= 8'h00;
        end
        2'h2: if (cnt_ff == 8'(HOLD)) begin
          o_line_n <= 1'b0;
          st_ff <= 2'h0;
        end
        default: st_ff <= 2'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: tb/mpb_bus_share_tb.sv
// Self-checking bench for the bus-sharing block.
// Assumes two borrower models on the request/grant lines.
`timescale 1ns/100ps
`default_nettype none
module mpb_bus_share_tb;
  localparam logic [5:0] P = 6'h01, E = 6'h02, W = 6'h04, F = 6'h08, L = 6'h10, H = 6'h20;
  logic i_mclk, i_rst, i_max_mode, i_prefix_exec, i_instr_end, i_rep_active;
  logic i_inta_active, i_wait_exec, i_sync_n, i_esc_fetch, i_cycle_busy;
  logic i_eu_needs_bus, i_queue_empty, i_takeover_req, hi_go, lo_go;
  logic [5:0] i_esc_sel, o_handoff_sel;
  logic [1:0] i_queue_state;
  logic o_req_grant_high_prio_n, o_req_grant_high_prio_oe_n, o_req_grant_low_prio_n;
  logic o_req_grant_low_prio_oe_n, o_exclusive_n, o_takeover_acknowledge;
  logic o_bus_interface_unit_off, o_execution_unit_stall, o_wait_done;
  logic o_coprocessor_handoff_instr, o_queue_state_bit0, o_queue_state_bit1;
  logic hi_drv_n, lo_drv_n, hi_own, lo_own;
  int fails, n_tests;
  // ----
  // Wired lines, pulled up when released
  // ----
  wire i_req_grant_high_prio_n = (o_req_grant_high_prio_oe_n | o_req_grant_high_prio_n) & hi_drv_n;
  wire i_req_grant_low_prio_n = (o_req_grant_low_prio_oe_n | o_req_grant_low_prio_n) & lo_drv_n;
  mpb_bus_share dut_u (.*);
  mpb_borrower #(.HOLD(6)) hi_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_go(hi_go),
    .i_line_n(i_req_grant_high_prio_n), .o_line_n(hi_drv_n), .o_owner(hi_own));
  mpb_borrower #(.HOLD(3)) lo_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_go(lo_go),
    .i_line_n(i_req_grant_low_prio_n), .o_line_n(lo_drv_n), .o_owner(lo_own));
  // Clock and watchdog
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  initial begin
    #20000;
    fails++;
    results();
  end
  task automatic chkv(input logic [5:0] got, input logic [5:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic got, input logic exp);
    chkv({5'h00, got}, {5'h00, exp});
  endtask
  // One-clock command pulses: hi, lo, fetch, wait, end, prefix
  task automatic pulse(input logic [5:0] m);
    @(posedge i_mclk);
    {hi_go, lo_go, i_esc_fetch, i_wait_exec, i_instr_end, i_prefix_exec} <= m;
    @(posedge i_mclk);
    {hi_go, lo_go, i_esc_fetch, i_wait_exec, i_instr_end, i_prefix_exec} <= 6'h00;
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return hi_own;
      1: return lo_own;
      2: return o_bus_interface_unit_off;
      3: return o_takeover_acknowledge;
      default: return o_wait_done;
    endcase
  endfunction
  task automatic await(input int k, input logic v);
    for (int n = 0; n < 40 && sig(k) !== v; n++) @(negedge i_mclk);
    chk(sig(k), v);
  endtask
  task automatic t_lock();
    pulse(P);
    repeat (2) @(negedge i_mclk);
    chk(o_exclusive_n, 1'b0);
    repeat (3) @(negedge i_mclk);
    chk(o_exclusive_n, 1'b0);
    pulse(E);
    @(negedge i_mclk);
    chk(o_exclusive_n, 1'b1);
    pulse(P);
    pulse(E);
    @(negedge i_mclk);
    chk(o_exclusive_n, 1'b1);
    pulse(P);
    repeat (2) @(negedge i_mclk);
    chk(o_exclusive_n, 1'b0);
    i_rep_active <= 1'b1;
    pulse(E);
    @(negedge i_mclk);
    chk(o_exclusive_n, 1'b0);
    @(posedge i_mclk);
    i_rep_active <= 1'b0;
    i_inta_active <= 1'b1;
    pulse(E);
    @(negedge i_mclk);
    chk(o_exclusive_n, 1'b0);
    @(posedge i_mclk);
    i_inta_active <= 1'b0;
    repeat (2) @(negedge i_mclk);
    chk(o_exclusive_n, 1'b1);
    $display("t_lock done");
  endtask
  task automatic t_min();
    @(posedge i_mclk);
    i_max_mode <= 1'b0;
    pulse(P);
    i_takeover_req <= 1'b1;
    repeat (4) @(negedge i_mclk);
    chk(o_exclusive_n, 1'b1);
    chk(o_takeover_acknowledge, 1'b0);
    pulse(E);
    await(3, 1'b1);
    @(posedge i_mclk);
    i_takeover_req <= 1'b0;
    await(3, 1'b0);
    @(posedge i_mclk);
    i_cycle_busy <= 1'b1;
    i_takeover_req <= 1'b1;
    repeat (4) @(negedge i_mclk);
    chk(o_takeover_acknowledge, 1'b0);
    @(posedge i_mclk);
    i_cycle_busy <= 1'b0;
    await(3, 1'b1);
    @(posedge i_mclk);
    i_takeover_req <= 1'b0;
    i_max_mode <= 1'b1;
    await(3, 1'b0);
    $display("t_min done");
  endtask
  task automatic t_wait_esc();
    @(posedge i_mclk);
    i_sync_n <= 1'b0;
    i_esc_sel <= 6'h2D;
    i_queue_state <= 2'h3;
    pulse(W | F);
    @(negedge i_mclk);
    chk(o_wait_done, 1'b1);
    chk(o_coprocessor_handoff_instr, 1'b1);
    chkv(o_handoff_sel, 6'h2D);
    chkv({4'h0, o_queue_state_bit1, o_queue_state_bit0}, 6'h03);
    @(posedge i_mclk);
    i_sync_n <= 1'b1;
    i_queue_state <= 2'h2;
    pulse(W);
    repeat (4) @(negedge i_mclk);
    chk(o_wait_done, 1'b0);
    chkv({4'h0, o_queue_state_bit1, o_queue_state_bit0}, 6'h02);
    @(posedge i_mclk);
    i_sync_n <= 1'b0;
    @(negedge i_mclk);
    chk(o_wait_done, 1'b0);
    @(negedge i_mclk);
    chk(o_wait_done, 1'b1);
    $display("t_wait_esc done");
  endtask
  task automatic t_grant();
    pulse(H);
    await(0, 1'b1);
    chk(o_bus_interface_unit_off, 1'b1);
    @(posedge i_mclk);
    i_eu_needs_bus <= 1'b1;
    repeat (3) @(negedge i_mclk);
    chk(o_execution_unit_stall, 1'b1);
    @(posedge i_mclk);
    i_eu_needs_bus <= 1'b0;
    await(0, 1'b0);
    await(2, 1'b0);
    pulse(H | L);
    await(0, 1'b1);
    chk(lo_own, 1'b0);
    await(2, 1'b0);
    await(1, 1'b1);
    await(2, 1'b0);
    pulse(L);
    await(1, 1'b1);
    pulse(H);
    await(1, 1'b0);
    chk(hi_own, 1'b0);
    await(0, 1'b1);
    await(2, 1'b0);
    pulse(P);
    pulse(H);
    repeat (6) @(negedge i_mclk);
    chk(hi_own, 1'b0);
    pulse(E);
    await(0, 1'b1);
    await(2, 1'b0);
    $display("t_grant done");
  endtask
  task automatic results();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    fails = 0;
    n_tests = 0;
    i_rst = 1'b1;
    {i_max_mode, i_sync_n} = 2'h3;
    {i_prefix_exec, i_instr_end, i_rep_active, i_inta_active, i_wait_exec} = 5'h00;
    {i_esc_fetch, i_cycle_busy, i_eu_needs_bus, i_queue_empty, i_takeover_req} = 5'h00;
    {hi_go, lo_go, i_esc_sel, i_queue_state} = 10'h000;
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(negedge i_mclk);
    chk(o_exclusive_n, 1'b1);
    chk(o_req_grant_high_prio_oe_n, 1'b1);
    t_lock();
    t_min();
    t_wait_esc();
    t_grant();
    results();
  end
endmodule
`default_nettype wire
